/* verilog/dtp_top.sv */
// directory cache and in-flight tracker performance subcounters
// assumes tracker/directory strobes are synchronous to clk_sys_i
`timescale 1ns/1ps
module dtp_top #(
   parameter int TRK_N = 48
) (
   input  wire logic                  clk_sys_i,
   input  wire logic                  arst_n_i,
   input  wire logic                  ce_i,
   input  wire logic                  freeze_i,
   input  wire logic [TRK_N-1:0]      trk_alloc_i,
   input  wire logic [TRK_N-1:0]      trk_free_i,
   input  wire dtp_pkg::dtp_txn_s     dir_insert_i,
   input  wire dtp_pkg::dtp_txn_s     dir_retire_i,
   input  wire dtp_pkg::dtp_req_s     req_i,
   output logic [63:0]                rdata_o,
   output logic                       tracker_overflow_event_o,
   output logic [3:0]                 generic_directory_event_o
);

   // ************************************************************
   // state
   // ************************************************************
   logic [TRK_N-1:0]          trk_valid_reg;
   logic [dtp_pkg::LIVE_W-1:0] trk_live;
   logic [dtp_pkg::ACC_W-1:0]  trk_acc;
   logic [dtp_pkg::LIVE_W-1:0] dir_live_reg;
   logic [dtp_pkg::LIVE_W-1:0] dir_live_next;
   logic [dtp_pkg::ACC_W-1:0]  dir_acc;
   logic [19:0]               sel_reg;
   logic [15:0]               opc_reg;
   logic [6:0]                thr_reg;
   logic                      dir_en_reg;
   logic [63:0]               rdata_reg;
   logic                      arrive_reg;
   logic                      retire_reg;
   logic                      ins_hit;
   logic                      ret_hit;
   logic                      wr_trk;
   logic                      wr_dir;
   logic                      wr_sel;
   logic                      wr_opc;
   logic                      wr_thr;
   logic                      wr_ctl;
   logic                      thresh;

   // ************************************************************
   // register strobes
   // ************************************************************
   assign wr_trk = req_i.wr & (req_i.addr == dtp_pkg::TRK_CNT_OFS);
   assign wr_dir = req_i.wr & (req_i.addr == dtp_pkg::DIR_CNT_OFS);
   assign wr_sel = req_i.wr & (req_i.addr == dtp_pkg::DIR_SEL_OFS);
   assign wr_opc = req_i.wr & (req_i.addr == dtp_pkg::OPC_FLT_OFS);
   assign wr_thr = req_i.wr & (req_i.addr == dtp_pkg::THR_OFS);
   assign wr_ctl = req_i.wr & (req_i.addr == dtp_pkg::PERF_CTL_OFS);

   // ************************************************************
   // in-flight tracker occupancy
   // ************************************************************

   // one flop per entry; allocation wins over a same-cycle free
   genvar g;
   generate
      for (g = 0; g < TRK_N; g++)
      begin : g_trk
         always_ff @(posedge clk_sys_i or negedge arst_n_i)
         begin
            if (!arst_n_i)
               trk_valid_reg[g] <= 1'b0;
            else if (ce_i)
            begin
               if (trk_alloc_i[g])
                  trk_valid_reg[g] <= 1'b1;
               else if (trk_free_i[g])
                  trk_valid_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // live tracker count is the population of the valid vector
   always_comb
   begin
      trk_live = '0;
      for (int i = 0; i < TRK_N; i++)
         trk_live = trk_live + dtp_pkg::LIVE_W'(trk_valid_reg[i]);
   end

   // tracker accumulator stops under freeze, unlike the directory live count
   dtp_accum #(
      .LIVE_W (dtp_pkg::LIVE_W),
      .ACC_W  (dtp_pkg::ACC_W)
   ) u_trk_acc (
      .clk_sys_i  (clk_sys_i),
      .arst_n_i   (arst_n_i),
      .ce_i       (ce_i),
      .run_i      (~freeze_i),
      .live_i     (trk_live),
      .load_i     (wr_trk),
      .load_val_i (req_i.wdata[dtp_pkg::ACC_W-1:0]),
      .acc_o      (trk_acc)
   );

   assign tracker_overflow_event_o = trk_acc[dtp_pkg::ACC_W-1];

   // ************************************************************
   // directory cache outstanding count
   // ************************************************************

   // decoded mask: each opcode value picks one bit of the filter
   assign ins_hit = dir_insert_i.valid & opc_reg[dir_insert_i.opcode];
   assign ret_hit = dir_retire_i.valid & opc_reg[dir_retire_i.opcode];

   always_comb
   begin
      dir_live_next = dir_live_reg;
      if (ins_hit && !ret_hit)
         dir_live_next = dir_live_reg + 6'h01;
      else if (ret_hit && !ins_hit)
         dir_live_next = dir_live_reg - 6'h01;
   end

   // freeze is deliberately not looked at here
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         dir_live_reg <= dtp_pkg::LIVE_RST;
      else if (ce_i)
      begin
         if (wr_opc)
            dir_live_reg <= dtp_pkg::LIVE_RST;
         else if (wr_dir)
            dir_live_reg <= req_i.wdata[dtp_pkg::DIR_LIVE_LSB +: dtp_pkg::LIVE_W];
         else
            dir_live_reg <= dir_live_next;
      end
   end

   dtp_accum #(
      .LIVE_W (dtp_pkg::LIVE_W),
      .ACC_W  (dtp_pkg::ACC_W)
   ) u_dir_acc (
      .clk_sys_i  (clk_sys_i),
      .arst_n_i   (arst_n_i),
      .ce_i       (ce_i),
      .run_i      (~freeze_i),
      .live_i     (dir_live_reg),
      .load_i     (wr_dir),
      .load_val_i (req_i.wdata[dtp_pkg::ACC_W-1:0]),
      .acc_o      (dir_acc)
   );

   // ************************************************************
   // control registers
   // ************************************************************

   // selector codes; upper write bits are dropped
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         sel_reg <= dtp_pkg::SEL_RST;
      else if (ce_i && wr_sel)
         sel_reg <= req_i.wdata[19:0];
   end

   // decoded opcode filter, shared by inserts and retirements
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         opc_reg <= dtp_pkg::OPC_RST;
      else if (ce_i && wr_opc)
         opc_reg <= req_i.wdata[dtp_pkg::OPC_W-1:0];
   end

   // threshold mode and value
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         thr_reg <= dtp_pkg::THR_RST;
      else if (ce_i && wr_thr)
         thr_reg <= req_i.wdata[6:0];
   end

   // event enable is off after reset, so no directory event leaks before software is ready
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         dir_en_reg <= 1'b0;
      else if (ce_i && wr_ctl)
         dir_en_reg <= req_i.wdata[dtp_pkg::DIR_EN_BIT];
   end

   // ************************************************************
   // sub-event sources
   // ************************************************************

   // matched insert pulse, registered so the event output comes from a flop
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         arrive_reg <= 1'b0;
      else if (ce_i)
         arrive_reg <= ins_hit;
   end

   // matched retirement pulse, same one-cycle lag as the insert pulse
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         retire_reg <= 1'b0;
      else if (ce_i)
         retire_reg <= ret_hit;
   end

   // threshold mode bit 6: one means at-or-above, zero means at-or-below
   always_comb
   begin
      if (thr_reg[dtp_pkg::THR_MODE_BIT])
         thresh = dir_live_reg >= thr_reg[5:0];
      else
         thresh = dir_live_reg <= thr_reg[5:0];
   end

   generate
      for (g = 0; g < 4; g++)
      begin : g_sel
         dtp_select u_sel (
            .code_i     (sel_reg[g*dtp_pkg::SEL_W +: dtp_pkg::SEL_W]),
            .enable_i   (dir_en_reg),
            .wrap_i     (dir_acc[dtp_pkg::ACC_W-1]),
            .arrive_i   (arrive_reg),
            .retire_i   (retire_reg),
            .thresh_i   (thresh),
            .full_i     (dir_live_reg == dtp_pkg::DIR_FULL_CNT),
            .nonempty_i (dir_live_reg != 6'h00),
            .event_o    (generic_directory_event_o[g])
         );
      end
   endgenerate

   // ************************************************************
   // read port
   // ************************************************************

   // read data valid one cycle after the strobe; zero after any other enabled edge, held while ce_i is low
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         rdata_reg <= 64'h0;
      else if (ce_i)
      begin
         rdata_reg <= 64'h0;
         if (req_i.rd)
         begin
            case (req_i.addr)
               dtp_pkg::TRK_CNT_OFS:
                  rdata_reg <= {trk_valid_reg, 3'h0, trk_live, trk_acc};
               dtp_pkg::DIR_CNT_OFS:
                  rdata_reg <= {42'h0, dir_live_reg, 9'h0, dir_acc};
               dtp_pkg::DIR_SEL_OFS:
                  rdata_reg <= {44'h0, sel_reg};
               dtp_pkg::OPC_FLT_OFS:
                  rdata_reg <= {48'h0, opc_reg};
               dtp_pkg::THR_OFS:
                  rdata_reg <= {57'h0, thr_reg};
               dtp_pkg::PERF_CTL_OFS:
                  rdata_reg <= {63'h0, dir_en_reg};
               default:
                  rdata_reg <= 64'h0;
            endcase
         end
      end
   end

   assign rdata_o = rdata_reg;

endmodule

/* verilog/dtp_pkg.sv */
// package of constants and carrier types for the directory/tracker subcounters
// assumes a single core clock domain and a simple strobe register port
package dtp_pkg;

   // ************************************************************
   // register map (word offsets chosen for this block)
   // ************************************************************
   localparam logic [3:0] TRK_CNT_OFS  = 4'h0;
   localparam logic [3:0] DIR_CNT_OFS  = 4'h1;
   localparam logic [3:0] DIR_SEL_OFS  = 4'h2;
   localparam logic [3:0] OPC_FLT_OFS  = 4'h3;
   localparam logic [3:0] THR_OFS      = 4'h4;
   localparam logic [3:0] PERF_CTL_OFS = 4'h5;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int TRK_VALID_LSB = 16;
   localparam int TRK_LIVE_LSB  = 7;
   localparam int DIR_LIVE_LSB  = 16;
   localparam int ACC_LSB       = 0;
   localparam int SEL_W         = 5;
   localparam int SEL_A_LSB     = 0;
   localparam int SEL_B_LSB     = 5;
   localparam int SEL_C_LSB     = 10;
   localparam int SEL_D_LSB     = 15;
   localparam int THR_MODE_BIT  = 6;
   localparam int DIR_EN_BIT    = 0;

   // ************************************************************
   // widths and reset values
   // ************************************************************
   localparam int LIVE_W = 6;
   localparam int ACC_W  = 7;
   localparam int OPC_W  = 16;
   localparam int CODE_W = 4;
   localparam logic [5:0]  DIR_FULL_CNT  = 6'h20;
   localparam logic [15:0] OPC_RST       = 16'h0000;
   localparam logic [19:0] SEL_RST       = 20'h00000;
   localparam logic [6:0]  ACC_RST       = 7'h00;
   localparam logic [5:0]  LIVE_RST      = 6'h00;
   localparam logic [6:0]  THR_RST       = 7'h00;
   localparam logic [4:0]  FILTER_MAX    = 5'h06;
   localparam logic [4:0]  GATED_MAX     = 5'h07;

   // sub-event selection codes
   typedef enum logic [4:0] {
      DTP_SEL_WRAP    = 5'h00,
      DTP_SEL_ARRIVE  = 5'h01,
      DTP_SEL_RETIRE  = 5'h02,
      DTP_SEL_THRESH  = 5'h03,
      DTP_SEL_FULL    = 5'h04,
      DTP_SEL_NONEMPT = 5'h05
   } dtp_sel_e;

   // one transaction event from the directory cache pipeline
   typedef struct packed {
      logic             valid;
      logic [CODE_W-1:0] opcode;
   } dtp_txn_s;

   // register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [63:0] wdata;
   } dtp_req_s;

endpackage

/* verilog/dtp_accum.sv */
// seven-bit occupancy accumulator with wrap and software load
// assumes load and tick come from logic on clk_sys_i
`timescale 1ns/1ps
module dtp_accum #(
   parameter int LIVE_W = 6,
   parameter int ACC_W  = 7
) (
   input  wire logic              clk_sys_i,
   input  wire logic              arst_n_i,
   input  wire logic              ce_i,
   input  wire logic              run_i,
   input  wire logic [LIVE_W-1:0] live_i,
   input  wire logic              load_i,
   input  wire logic [ACC_W-1:0]  load_val_i,
   output logic      [ACC_W-1:0]  acc_o
);

   logic [ACC_W-1:0] acc_reg;
   logic [ACC_W-1:0] acc_next;

   // wrap-around sum, the top bit is the overflow seen downstream
   always_comb
   begin
      acc_next = acc_reg + ACC_W'(live_i);
   end

   // software load wins over accumulation
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         acc_reg <= '0;
      else if (ce_i)
      begin
         if (load_i)
            acc_reg <= load_val_i;
         else if (run_i)
            acc_reg <= acc_next;
      end
   end

   assign acc_o = acc_reg;

endmodule

/* verilog/dtp_select.sv */
// one sub-event selector: code to event mux with enable gating
// assumes all inputs are registered state on clk_sys_i
`timescale 1ns/1ps
module dtp_select (
   input  wire logic [4:0] code_i,
   input  wire logic       enable_i,
   input  wire logic       wrap_i,
   input  wire logic       arrive_i,
   input  wire logic       retire_i,
   input  wire logic       thresh_i,
   input  wire logic       full_i,
   input  wire logic       nonempty_i,
   output logic            event_o
);

   logic raw;

   // codes above five are not decoded by any selector and give nothing here
   always_comb
   begin
      case (code_i)
         dtp_pkg::DTP_SEL_WRAP:    raw = wrap_i;
         dtp_pkg::DTP_SEL_ARRIVE:  raw = arrive_i;
         dtp_pkg::DTP_SEL_RETIRE:  raw = retire_i;
         dtp_pkg::DTP_SEL_THRESH:  raw = thresh_i;
         dtp_pkg::DTP_SEL_FULL:    raw = full_i;
         dtp_pkg::DTP_SEL_NONEMPT: raw = nonempty_i;
         default:                  raw = 1'b0;
      endcase
      event_o = raw & (enable_i | (code_i > dtp_pkg::GATED_MAX));
   end

endmodule

/* verification/dtp_checker.sv */
// checker of the subcounter block, watching its top-level ports only
// assumes one clock domain and a register port with one-cycle strobes
`timescale 1ns/1ps
module dtp_checker (
   input wire logic              clk_sys_i,
   input wire logic              arst_n_i,
   input wire logic              ce_i,
   input wire logic              freeze_i,
   input wire dtp_pkg::dtp_txn_s dir_insert_i,
   input wire dtp_pkg::dtp_txn_s dir_retire_i,
   input wire dtp_pkg::dtp_req_s req_i,
   input wire logic [63:0]       rdata_o,
   input wire logic              tracker_overflow_event_o,
   input wire logic [3:0]        generic_directory_event_o
);
   // ****************************************
   // shadow of the software settings
   // ****************************************
   logic        en_reg;
   logic [19:0] sel_reg;
   logic [15:0] mask_reg;
   logic        quiet;

   // no directory traffic, so the live count can only move by software
   assign quiet = !dir_insert_i.valid && !dir_retire_i.valid;

   // follow writes on the same edge the block takes them
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         en_reg   <= 1'b0;
         sel_reg  <= 20'h00000;
         mask_reg <= 16'h0000;
      end
      else if (ce_i && req_i.wr)
      begin
         if (req_i.addr == dtp_pkg::PERF_CTL_OFS) en_reg <= req_i.wdata[0];
         if (req_i.addr == dtp_pkg::DIR_SEL_OFS) sel_reg <= req_i.wdata[19:0];
         if (req_i.addr == dtp_pkg::OPC_FLT_OFS) mask_reg <= req_i.wdata[15:0];
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   a_idle_read_zero :
   assert property ($past(ce_i && !req_i.rd) |-> rdata_o == 64'h0)
      else $error("read data not zero outside a read answer");
   a_unmapped_zero :
   assert property ($past(ce_i && req_i.rd && req_i.addr > 4'h5) |-> rdata_o == 64'h0)
      else $error("unmapped read not zero");
   a_select_readback :
   assert property ($past(ce_i && req_i.rd && req_i.addr == dtp_pkg::DIR_SEL_OFS)
      |-> rdata_o == {44'h0, $past(sel_reg)}) else $error("selector read back wrong");
   a_filter_readback :
   assert property ($past(ce_i && req_i.rd && req_i.addr == dtp_pkg::OPC_FLT_OFS)
      |-> rdata_o == {48'h0, $past(mask_reg)}) else $error("filter read back wrong");
   a_tracker_gap_zero :
   assert property ($past(ce_i && req_i.rd && req_i.addr == dtp_pkg::TRK_CNT_OFS)
      |-> rdata_o[15:13] == 3'h0) else $error("tracker unused bits not zero");
   a_dir_gap_zero :
   assert property ($past(ce_i && req_i.rd && req_i.addr == dtp_pkg::DIR_CNT_OFS)
      |-> rdata_o[63:22] == 42'h0 && rdata_o[15:7] == 9'h0)
      else $error("directory unused bits not zero");
   a_disabled_quiet :
   assert property (!en_reg |-> generic_directory_event_o == 4'h0)
      else $error("event while directory events off");
   a_arrive_pulse :
   assert property (en_reg && sel_reg[4:0] == 5'h01 |-> generic_directory_event_o[0]
      == $past(dir_insert_i.valid && mask_reg[dir_insert_i.opcode]))
      else $error("arrival pulse wrong");
   a_retire_pulse :
   assert property (en_reg && sel_reg[9:5] == 5'h02 |-> generic_directory_event_o[1]
      == $past(dir_retire_i.valid && mask_reg[dir_retire_i.opcode]))
      else $error("retire pulse wrong");
   a_filter_clears :
   assert property ((req_i.wr && req_i.addr == dtp_pkg::OPC_FLT_OFS && quiet)
      ##1 (quiet && !req_i.wr) ##1 (req_i.rd && req_i.addr == dtp_pkg::DIR_CNT_OFS)
      |=> rdata_o[21:16] == 6'h0) else $error("filter write left live count");
   a_tracker_frozen :
   assert property (freeze_i && !req_i.wr |=> $stable(tracker_overflow_event_o))
      else $error("tracker overflow moved while frozen");
   a_wrap_frozen :
   assert property (freeze_i && !req_i.wr && en_reg && sel_reg[4:0] == 5'h00
      |=> $stable(generic_directory_event_o[0])) else $error("wrap moved while frozen");
endmodule

bind dtp_top dtp_checker u_chk (
   .clk_sys_i                (clk_sys_i),
   .arst_n_i                 (arst_n_i),
   .ce_i                     (ce_i),
   .freeze_i                 (freeze_i),
   .dir_insert_i             (dir_insert_i),
   .dir_retire_i             (dir_retire_i),
   .req_i                    (req_i),
   .rdata_o                  (rdata_o),
   .tracker_overflow_event_o (tracker_overflow_event_o),
   .generic_directory_event_o(generic_directory_event_o)
);

/* verification/dtp_main_counters.sv */
// model of the main performance counters fed by the subcounter events
// assumes event levels are sampled once per core clock
`timescale 1ns/1ps
module dtp_main_counters (
   input  wire logic             clk_sys_i,
   input  wire logic             arst_n_i,
   input  wire logic             overflow_i,
   input  wire logic [3:0]       event_i,
   output logic      [15:0]      ovf_hits_o,
   output logic      [3:0][15:0] event_hits_o
);
   // each line adds one per cycle it stands high; no edge detect, so a
   // stuck level shows as a runaway count
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ovf_hits_o   <= 16'h0000;
         event_hits_o <= '0;
      end
      else
      begin
         ovf_hits_o <= ovf_hits_o + 16'(overflow_i);
         for (int i = 0; i < 4; i++)
         begin
            event_hits_o[i] <= event_hits_o[i] + 16'(event_i[i]);
         end
      end
   end
endmodule

/* verification/tb_directory_tracker_perf_subcounters.sv */
// self-checking bench of the subcounter block and its main-counter model
// assumes a 50 MHz core clock and the checker bound into the top module
`timescale 1ns/1ps
module tb_directory_tracker_perf_subcounters;
   logic              clk_sys_i;
   logic              arst_n_i;
   logic              ce_i;
   logic              freeze_i;
   logic [47:0]       trk_alloc_i;
   logic [47:0]       trk_free_i;
   dtp_pkg::dtp_txn_s dir_insert_i;
   dtp_pkg::dtp_txn_s dir_retire_i;
   dtp_pkg::dtp_req_s req_i;
   logic [63:0]       rdata_o;
   logic              trk_ovf;
   logic [3:0]        gen_ev;
   logic [15:0]       ovf_hits;
   logic [3:0][15:0]  ev_hits;
   int                err_count;
   int                comparisons;

   dtp_top #(.TRK_N(48)) u_dut (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .freeze_i(freeze_i),
      .trk_alloc_i(trk_alloc_i), .trk_free_i(trk_free_i), .dir_insert_i(dir_insert_i),
      .dir_retire_i(dir_retire_i), .req_i(req_i), .rdata_o(rdata_o),
      .tracker_overflow_event_o(trk_ovf), .generic_directory_event_o(gen_ev));
   dtp_main_counters u_main (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .overflow_i(trk_ovf),
      .event_i(gen_ev), .ovf_hits_o(ovf_hits), .event_hits_o(ev_hits));

   // ****************************************
   // clock, shared tasks
   // ****************************************
   initial
   begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   task automatic results;
      if (err_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [63:0] d);
      @(posedge clk_sys_i);
      req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys_i);
      req_i <= '0;
      #1;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rdchk(input logic [3:0] a, input logic [63:0] exp);
      @(posedge clk_sys_i);
      req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 64'h0};
      @(posedge clk_sys_i);
      req_i <= '0;
      #1;
      chk(rdata_o, exp);
   endtask

   task automatic trk(input logic [47:0] al, input logic [47:0] fr);
      @(posedge clk_sys_i);
      trk_alloc_i <= al;
      trk_free_i  <= fr;
      @(posedge clk_sys_i);
      trk_alloc_i <= '0;
      trk_free_i  <= '0;
   endtask

   task automatic dop(input logic i, input logic r, input logic [3:0] opc);
      @(posedge clk_sys_i);
      dir_insert_i <= '{valid: i, opcode: opc};
      dir_retire_i <= '{valid: r, opcode: opc};
      @(posedge clk_sys_i);
      dir_insert_i <= '0;
      dir_retire_i <= '0;
      #1;
   endtask

   // lift freeze for exactly n accumulating edges
   task automatic run(input int n);
      @(posedge clk_sys_i);
      freeze_i <= 1'b0;
      repeat (n) @(posedge clk_sys_i);
      freeze_i <= 1'b1;
      #1;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs;
      for (int a = 0; a < 7; a++) rdchk(4'(a), 64'h0);
      wr(dtp_pkg::DIR_SEL_OFS, '1);
      rdchk(dtp_pkg::DIR_SEL_OFS, 64'hFFFFF);
      wr(dtp_pkg::OPC_FLT_OFS, '1);
      rdchk(dtp_pkg::OPC_FLT_OFS, 64'hFFFF);
      wr(dtp_pkg::DIR_CNT_OFS, '1);
      rdchk(dtp_pkg::DIR_CNT_OFS, 64'h3F_007F);
      wr(dtp_pkg::TRK_CNT_OFS, '1);
      rdchk(dtp_pkg::TRK_CNT_OFS, 64'h7F);
      chk(trk_ovf, 1'b1);
      wr(4'h6, '1);
      rdchk(4'h6, 64'h0);
      wr(dtp_pkg::OPC_FLT_OFS, 64'h0);
      rdchk(dtp_pkg::DIR_CNT_OFS, 64'h7F);
      wr(dtp_pkg::DIR_CNT_OFS, 64'h0);
      wr(dtp_pkg::TRK_CNT_OFS, 64'h0);
      wr(dtp_pkg::DIR_SEL_OFS, 64'h0);
   endtask

   // clock enable low: a selector write in that cycle must not land
   task automatic t_hold;
      @(posedge clk_sys_i);
      ce_i <= 1'b0;
      wr(dtp_pkg::DIR_SEL_OFS, '1);
      @(posedge clk_sys_i);
      ce_i <= 1'b1;
      rdchk(dtp_pkg::DIR_SEL_OFS, 64'h0);
   endtask

   task automatic t_tracker;
      trk(48'h1, 48'h0);
      trk(48'h8000_0000_0000, 48'h0);
      rdchk(dtp_pkg::TRK_CNT_OFS, 64'h8000_0000_0001_0100);
      trk(48'h0, 48'h8000_0000_0001);
      rdchk(dtp_pkg::TRK_CNT_OFS, 64'h0);
      trk(48'h20, 48'h0);
      wr(dtp_pkg::TRK_CNT_OFS, 64'h3F);
      chk(trk_ovf, 1'b0);
      run(1);
      chk(trk_ovf, 1'b1);
      rdchk(dtp_pkg::TRK_CNT_OFS, 64'h20_00C0);
      run(5);
      rdchk(dtp_pkg::TRK_CNT_OFS, 64'h20_00C5);
      run(60);
      rdchk(dtp_pkg::TRK_CNT_OFS, 64'h20_0081);
      chk(trk_ovf, 1'b0);
      trk(48'h0, 48'h20);
      wr(dtp_pkg::TRK_CNT_OFS, 64'h0);
   endtask

   task automatic t_dir;
      logic [6:0] thr [4];
      thr = '{7'h60, 7'h61, 7'h1F, 7'h20};
      wr(dtp_pkg::OPC_FLT_OFS, 64'h8);
      wr(dtp_pkg::DIR_SEL_OFS, 64'h29041);
      wr(dtp_pkg::PERF_CTL_OFS, 64'h1);
      dop(1'b1, 1'b1, 4'h5);
      chk(gen_ev, 4'h0);
      dop(1'b1, 1'b0, 4'h3);
      chk(gen_ev, 4'h9);
      rdchk(dtp_pkg::DIR_CNT_OFS, 64'h1_0000);
      dop(1'b1, 1'b1, 4'h3);
      chk(gen_ev, 4'hB);
      dop(1'b1, 1'b0, 4'h3);
      rdchk(dtp_pkg::DIR_CNT_OFS, 64'h2_0000);
      dop(1'b0, 1'b1, 4'h3);
      dop(1'b0, 1'b1, 4'h3);
      chk(gen_ev, 4'h2);
      @(posedge clk_sys_i); // the model counts the last retire pulse on this edge
      #1;
      chk(ev_hits[0], 16'd3);
      chk(ev_hits[1], 16'd3);
      for (int i = 0; i < 32; i++) dop(1'b1, 1'b0, 4'h3);
      chk(gen_ev, 4'hD);
      rdchk(dtp_pkg::DIR_CNT_OFS, 64'h20_0000);
      wr(dtp_pkg::DIR_SEL_OFS, 64'h28C41);
      for (int i = 0; i < 4; i++)
      begin
         wr(dtp_pkg::THR_OFS, {57'h0, thr[i]});
         chk(gen_ev[2], (i == 0 || i == 3));
      end
      wr(dtp_pkg::PERF_CTL_OFS, 64'h0);
      chk(gen_ev, 4'h0);
      wr(dtp_pkg::PERF_CTL_OFS, 64'h1);
      wr(dtp_pkg::OPC_FLT_OFS, 64'h8);
      rdchk(dtp_pkg::DIR_CNT_OFS, 64'h0);
      chk(gen_ev, 4'h4);
   endtask

   task automatic t_wrap;
      wr(dtp_pkg::DIR_SEL_OFS, 64'h0);
      wr(dtp_pkg::DIR_CNT_OFS, 64'h3F);
      chk(gen_ev, 4'h0);
      wr(dtp_pkg::DIR_CNT_OFS, 64'h40);
      chk(gen_ev, 4'hF);
      wr(dtp_pkg::DIR_CNT_OFS, 64'h3F);
      dop(1'b1, 1'b0, 4'h3);
      run(1);
      chk(gen_ev, 4'hF);
      rdchk(dtp_pkg::DIR_CNT_OFS, 64'h1_0040);
      wr(dtp_pkg::DIR_SEL_OFS, 64'h08421);
      chk(gen_ev, 4'h0);
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial
   begin
      err_count = 0;
      comparisons = 0;
      arst_n_i = 1'b0;
      ce_i = 1'b1;
      freeze_i = 1'b1;
      trk_alloc_i = '0;
      trk_free_i = '0;
      dir_insert_i = '0;
      dir_retire_i = '0;
      req_i = '0;
      repeat (6) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      t_regs();
      t_hold();
      t_tracker();
      t_dir();
      t_wrap();
      results();
   end

   // the scenarios need well under two thousand cycles
   initial
   begin
      #200000;
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      results();
   end
endmodule
